// *** shared/record_service_pkg.sv ***
// Package: constants and types for the record service decoder
//----------------------------------------------------------------
// Contract
// - Read 0x15 returns auto-address flag in byte 2
// - Slot 0 selects segment one, 100 segment two
// - Read 0x17 returns fault list, status byte 11
// - Faulted node sets its list bit
// - Healthy, disabled or absent node clears bit
// - Unmapped list positions carry no fault meaning
// - Write 0x18 applies byte 2 as ID1 to node 0
// - ID1 write reports success or node absent
// - Read 0x19 returns analog image, status byte 251
// - Four slots: single node or A/B pairs
// - Write 0x1A stores analog output image
// - Every response carries a status code
// - Auto-address status sits in byte 4
// - Write 0x15 sets auto-address enable from bit 0
//----------------------------------------------------------------
package record_service_pkg;

	// Function indices
	localparam logic [7:0] FN_AUTO_ADDR = 8'h15;
	localparam logic [7:0] FN_FAULT_LIST = 8'h17;
	localparam logic [7:0] FN_WRITE_ID1 = 8'h18;
	localparam logic [7:0] FN_ANALOG_IN = 8'h19;
	localparam logic [7:0] FN_ANALOG_OUT = 8'h1A;

	// Slot values per segment
	localparam logic [7:0] SLOT_SEG_ONE = 8'h00;
	localparam logic [7:0] SLOT_SEG_TWO = 8'h64;

	// Byte positions in the response
	localparam logic [7:0] BYTE_FLAG = 8'h02;
	localparam logic [7:0] BYTE_AUTO_STATUS = 8'h04;
	localparam logic [7:0] BYTE_LIST_FIRST = 8'h02;
	localparam logic [7:0] BYTE_LIST_LAST = 8'h09;
	localparam logic [7:0] BYTE_LIST_STATUS = 8'h0B;
	localparam logic [7:0] BYTE_IMG_FIRST = 8'h02;
	localparam logic [7:0] BYTE_IMG_LAST = 8'hF9;
	localparam logic [7:0] BYTE_IMG_STATUS = 8'hFB;

	// Status codes
	localparam logic [7:0] STATUS_OK = 8'h00;
	localparam logic [7:0] STATUS_FAILED = 8'h01;
	localparam logic [7:0] STATUS_NODE_ABSENT = 8'h02;

	// Reset values
	localparam logic RESET_AUTO_ADDR = 1'b0;

	// Image sizes
	localparam int NODE_COUNT = 32;
	localparam int IMG_WORDS = 124;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_STREAM = 2'b01,
		ST_SEG_WAIT = 2'b10
	} req_state_t;

endpackage : record_service_pkg

// *** hw/fault_list_map.sv ***
// Fault list mapper: node status to list bits
module fault_list_map
	import record_service_pkg::*;
(
	input wire logic [NODE_COUNT-1:0] i_fault_a,
	input wire logic [NODE_COUNT-1:0] i_fault_b,
	input wire logic [NODE_COUNT-1:0] i_active_a,
	input wire logic [NODE_COUNT-1:0] i_active_b,
	output logic [63:0] o_list
);

	//----------------------------------------------------------------
	// Per node bit generation
	//----------------------------------------------------------------
	// A bit is 1 only for an active node with a fault; positions 0 and 32 (node 0 of A and B) unused
	genvar g;
	generate
		for (g = 0; g < NODE_COUNT; g++) begin : g_node
			if (g == 0) begin : g_unmapped
				assign o_list[g] = 1'b0;
				assign o_list[32 + g] = 1'b0;
			end else begin : g_mapped
				assign o_list[g] = i_active_a[g] & i_fault_a[g];
				assign o_list[32 + g] = i_active_b[g] & i_fault_b[g];
			end
		end
	endgenerate

endmodule : fault_list_map

// *** hw/record_service_decoder.sv ***
// Record service decoder: acyclic read and write requests for two segments
//
// Design decisions made here: the plain strobed port and the register offsets.
module record_service_decoder
	import record_service_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Request
	input wire logic i_req_valid,
	input wire logic i_req_write,
	input wire logic [7:0] i_req_index,
	input wire logic [7:0] i_req_slot,
	input wire logic [7:0] i_req_id1,
	input wire logic [7:0] i_req_flag,
	// Analog output write stream, byte address and data
	input wire logic i_aout_valid,
	input wire logic [7:0] i_aout_addr,
	input wire logic [7:0] i_aout_data,
	// Response stream
	output logic o_busy,
	output logic o_rsp_valid,
	output logic [7:0] o_rsp_addr,
	output logic [7:0] o_rsp_data,
	output logic o_rsp_last,
	// Segment side: node state, analog inputs, command
	input wire logic [NODE_COUNT-1:0] i_seg0_fault_a,
	input wire logic [NODE_COUNT-1:0] i_seg0_fault_b,
	input wire logic [NODE_COUNT-1:0] i_seg0_active_a,
	input wire logic [NODE_COUNT-1:0] i_seg0_active_b,
	input wire logic [NODE_COUNT-1:0] i_seg1_fault_a,
	input wire logic [NODE_COUNT-1:0] i_seg1_fault_b,
	input wire logic [NODE_COUNT-1:0] i_seg1_active_a,
	input wire logic [NODE_COUNT-1:0] i_seg1_active_b,
	input wire logic [15:0] i_seg0_ain_word,
	input wire logic [15:0] i_seg1_ain_word,
	output logic [6:0] o_ain_word_sel,
	output logic o_seg_sel,
	output logic o_id1_cmd,
	output logic [7:0] o_id1_code,
	input wire logic i_id1_done,
	input wire logic i_id1_ok,
	output logic [1:0] o_auto_addr_en,
	output logic [15:0] o_aout_word,
	output logic [6:0] o_aout_sel,
	output logic o_aout_seg
);

	//----------------------------------------------------------------
	// Declarations
	//----------------------------------------------------------------
	req_state_t state_reg;
	logic [7:0] index_reg;
	logic [7:0] byte_reg;
	logic [7:0] last_reg;
	logic [7:0] status_reg;
	logic seg_reg;
	logic [1:0] auto_reg;
	logic [7:0] aout_low_reg;
	logic [63:0] list_seg0;
	logic [63:0] list_seg1;
	logic [63:0] list_sel;
	logic [15:0] ain_sel;
	logic slot_ok;
	logic index_ok;
	logic [7:0] rsp_byte;
	logic [7:0] img_off;
	logic [7:0] list_off;

	//----------------------------------------------------------------
	// Fault list per segment
	//----------------------------------------------------------------
	fault_list_map u_map0 (
		.i_fault_a(i_seg0_fault_a),
		.i_fault_b(i_seg0_fault_b),
		.i_active_a(i_seg0_active_a),
		.i_active_b(i_seg0_active_b),
		.o_list(list_seg0)
	);

	fault_list_map u_map1 (
		.i_fault_a(i_seg1_fault_a),
		.i_fault_b(i_seg1_fault_b),
		.i_active_a(i_seg1_active_a),
		.i_active_b(i_seg1_active_b),
		.o_list(list_seg1)
	);

	//----------------------------------------------------------------
	// Request decode
	//----------------------------------------------------------------
	// Only the two documented slot values reach a segment
	assign slot_ok = (i_req_slot == SLOT_SEG_ONE) || (i_req_slot == SLOT_SEG_TWO);

	// Known index per direction
	always_comb begin
		if (i_req_write) begin
			index_ok = (i_req_index == FN_AUTO_ADDR) || (i_req_index == FN_WRITE_ID1)
				|| (i_req_index == FN_ANALOG_OUT);
		end else begin
			index_ok = (i_req_index == FN_AUTO_ADDR) || (i_req_index == FN_FAULT_LIST)
				|| (i_req_index == FN_ANALOG_IN);
		end
	end

	//----------------------------------------------------------------
	// Request sequencer
	//----------------------------------------------------------------
	// Reads stream bytes 0..last, writes answer one status byte
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			state_reg <= ST_IDLE;
			index_reg <= 8'h00;
			byte_reg <= 8'h00;
			last_reg <= 8'h00;
			status_reg <= STATUS_OK;
			seg_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (i_req_valid) begin
						index_reg <= i_req_index;
						byte_reg <= 8'h00;
						// A refused request keeps the segment that tags output bytes
						if (slot_ok && index_ok) begin
							seg_reg <= (i_req_slot == SLOT_SEG_TWO);
						end
						if (!(slot_ok && index_ok)) begin
							status_reg <= STATUS_FAILED;
							last_reg <= 8'h00;
							state_reg <= ST_STREAM;
						end else if (i_req_write && i_req_index == FN_WRITE_ID1) begin
							state_reg <= ST_SEG_WAIT;
						end else begin
							status_reg <= STATUS_OK;
							state_reg <= ST_STREAM;
							if (i_req_write) begin
								last_reg <= 8'h00;
							end else if (i_req_index == FN_AUTO_ADDR) begin
								last_reg <= BYTE_AUTO_STATUS;
							end else if (i_req_index == FN_FAULT_LIST) begin
								last_reg <= BYTE_LIST_STATUS;
							end else begin
								last_reg <= BYTE_IMG_STATUS;
							end
						end
					end
				end
				ST_SEG_WAIT: begin
					if (i_id1_done) begin
						status_reg <= i_id1_ok ? STATUS_OK : STATUS_NODE_ABSENT;
						last_reg <= 8'h00;
						state_reg <= ST_STREAM;
					end
				end
				ST_STREAM: begin
					byte_reg <= byte_reg + 8'h01;
					if (byte_reg == last_reg) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	assign o_busy = (state_reg != ST_IDLE);

	//----------------------------------------------------------------
	// Stored state: auto-address enable per segment
	//----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			auto_reg <= {2{RESET_AUTO_ADDR}};
		end else if (state_reg == ST_IDLE && i_req_valid && i_req_write && slot_ok
			&& i_req_index == FN_AUTO_ADDR) begin
			auto_reg[i_req_slot == SLOT_SEG_TWO] <= i_req_flag[0];
		end
	end

	assign o_auto_addr_en = auto_reg;

	//----------------------------------------------------------------
	// ID1 command to the segment
	//----------------------------------------------------------------
	// One pulse carrying the new code for the node at address 0
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_id1_cmd <= 1'b0;
			o_id1_code <= 8'h00;
		end else begin
			o_id1_cmd <= state_reg == ST_IDLE && i_req_valid && i_req_write && slot_ok
				&& i_req_index == FN_WRITE_ID1;
			if (state_reg == ST_IDLE && i_req_valid && i_req_write && slot_ok
				&& i_req_index == FN_WRITE_ID1) begin
				o_id1_code <= i_req_id1;
			end
		end
	end

	assign o_seg_sel = seg_reg;

	//----------------------------------------------------------------
	// Analog output image: pair bytes into words
	//----------------------------------------------------------------
	// Even byte is the high half; odd byte completes and issues the word
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			aout_low_reg <= 8'h00;
			o_aout_word <= 16'h0000;
			o_aout_sel <= 7'h00;
			o_aout_seg <= 1'b0;
		end else if (i_aout_valid && i_aout_addr >= BYTE_IMG_FIRST
			&& i_aout_addr <= BYTE_IMG_LAST) begin
			if (!i_aout_addr[0]) begin
				aout_low_reg <= i_aout_data;
			end else begin
				o_aout_word <= {aout_low_reg, i_aout_data};
				o_aout_sel <= 7'((i_aout_addr - BYTE_IMG_FIRST) >> 1);
				o_aout_seg <= seg_reg;
			end
		end
	end

	//----------------------------------------------------------------
	// Response byte generation
	//----------------------------------------------------------------
	assign list_sel = seg_reg ? list_seg1 : list_seg0;
	assign ain_sel = seg_reg ? i_seg1_ain_word : i_seg0_ain_word;
	assign img_off = byte_reg - BYTE_IMG_FIRST;
	assign list_off = byte_reg - BYTE_LIST_FIRST;
	// Word select leads the byte so the segment answers combinationally
	assign o_ain_word_sel = 7'(img_off >> 1);

	always_comb begin
		rsp_byte = 8'h00;
		if (byte_reg == last_reg) begin
			rsp_byte = status_reg;
		end else if (index_reg == FN_AUTO_ADDR) begin
			if (byte_reg == BYTE_FLAG) begin
				rsp_byte = {7'h00, auto_reg[seg_reg]};
			end
		end else if (index_reg == FN_FAULT_LIST) begin
			if (byte_reg >= BYTE_LIST_FIRST && byte_reg <= BYTE_LIST_LAST) begin
				rsp_byte = list_sel[list_off[2:0]*8 +: 8];
			end
		end else if (index_reg == FN_ANALOG_IN) begin
			if (byte_reg >= BYTE_IMG_FIRST && byte_reg <= BYTE_IMG_LAST) begin
				rsp_byte = img_off[0] ? ain_sel[7:0] : ain_sel[15:8];
			end
		end
	end

	//----------------------------------------------------------------
	// Response registers
	//----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_rsp_valid <= 1'b0;
			o_rsp_addr <= 8'h00;
			o_rsp_data <= 8'h00;
			o_rsp_last <= 1'b0;
		end else begin
			o_rsp_valid <= (state_reg == ST_STREAM);
			o_rsp_addr <= byte_reg;
			o_rsp_data <= (state_reg == ST_STREAM) ? rsp_byte : 8'h00;
			o_rsp_last <= (state_reg == ST_STREAM) && (byte_reg == last_reg);
		end
	end

	//----------------------------------------------------------------
	// Checks
	//----------------------------------------------------------------
	a_bad_slot_fails: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_reg == ST_IDLE && i_req_valid && !slot_ok |=> status_reg == STATUS_FAILED
		&& state_reg == ST_STREAM)
		else $error("bad slot not refused");

	a_bad_req_keeps: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_reg == ST_IDLE && i_req_valid && !(slot_ok && index_ok) |=> $stable(auto_reg))
		else $error("refused request changed state");

	a_auto_write_sets: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_reg == ST_IDLE && i_req_valid && i_req_write && i_req_slot == SLOT_SEG_ONE
		&& i_req_index == FN_AUTO_ADDR |=> auto_reg[0] == $past(i_req_flag[0]))
		else $error("auto enable not stored");

	a_id1_status: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_reg == ST_SEG_WAIT && i_id1_done && !i_id1_ok
		|=> ##1 o_rsp_valid && o_rsp_last && o_rsp_data == STATUS_NODE_ABSENT)
		else $error("node absent status missing");

	a_id1_cmd_pulse: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_id1_cmd |-> state_reg == ST_SEG_WAIT && !$past(o_id1_cmd))
		else $error("ID1 command not one pulse");

	a_header_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_rsp_valid && o_rsp_addr <= 8'h01 && !o_rsp_last |-> o_rsp_data == 8'h00)
		else $error("header byte not zero");

	a_flag_byte: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_rsp_valid && index_reg == FN_AUTO_ADDR && o_rsp_addr == BYTE_FLAG
		|-> o_rsp_data[7:1] == 7'h00)
		else $error("flag byte reserved bits set");

	a_list_length: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_reg == ST_IDLE && i_req_valid && !i_req_write && slot_ok
		&& i_req_index == FN_FAULT_LIST |-> ##13 o_rsp_last && o_rsp_addr == BYTE_LIST_STATUS)
		else $error("fault list length wrong");

	a_list_bit0_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_rsp_valid && index_reg == FN_FAULT_LIST && o_rsp_addr == BYTE_LIST_FIRST
		|-> o_rsp_data[0] == 1'b0)
		else $error("unmapped fault bit set");

	a_write_one_byte: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_reg == ST_IDLE && i_req_valid && i_req_write && slot_ok && index_ok
		&& i_req_index != FN_WRITE_ID1 |-> ##2 o_rsp_valid && o_rsp_last && o_rsp_addr == 8'h00)
		else $error("write response not one status byte");

	a_auto_length: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_reg == ST_IDLE && i_req_valid && !i_req_write && slot_ok
		&& i_req_index == FN_AUTO_ADDR |-> ##6 o_rsp_last && o_rsp_addr == BYTE_AUTO_STATUS)
		else $error("auto query length wrong");

	a_image_length: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_reg == ST_IDLE && i_req_valid && !i_req_write && slot_ok
		&& i_req_index == FN_ANALOG_IN |-> ##253 o_rsp_last && o_rsp_addr == BYTE_IMG_STATUS)
		else $error("analog image length wrong");

	a_id1_code: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_id1_cmd |-> o_id1_code == $past(i_req_id1))
		else $error("ID1 code not taken from request");

	a_refused_seg: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_reg == ST_IDLE && i_req_valid && !(slot_ok && index_ok) |=> $stable(seg_reg))
		else $error("refused request changed segment");

	a_busy_ignores: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_reg != ST_IDLE && i_req_valid |=> $stable(index_reg) && $stable(auto_reg))
		else $error("request taken while busy");

	a_last_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_rsp_last |-> o_rsp_valid && !o_busy)
		else $error("status byte not final");

	a_aout_pair: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_aout_valid && i_aout_addr[0] && i_aout_addr >= BYTE_IMG_FIRST
		&& i_aout_addr <= BYTE_IMG_LAST |=> o_aout_word[7:0] == $past(i_aout_data))
		else $error("output word low byte wrong");

endmodule : record_service_decoder

// *** sim/segment_model.sv ***
// Segment model: analog input words and node 0 ID1 answers
module segment_model (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [6:0] i_ain_word_sel,
	input wire logic i_id1_cmd,
	input wire logic i_node0_present,
	input wire logic i_slow,
	output logic [15:0] o_seg0_ain_word,
	output logic [15:0] o_seg1_ain_word,
	output logic o_id1_done,
	output logic o_id1_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_reg;
	// Distinct high and low bytes per word and per segment
	assign o_seg0_ain_word = {1'b0, i_ain_word_sel, 1'b1, i_ain_word_sel};
	assign o_seg1_ain_word = {1'b1, i_ain_word_sel, 1'b0, ~i_ain_word_sel};
	// Outcome only meaningful with the done pulse, inverted otherwise
	assign o_id1_ok = o_id1_done ? i_node0_present : !i_node0_present;
	// Answer each command after a short or a long delay
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			wait_reg <= 4'h0;
			o_id1_done <= 1'b0;
		end else begin
			o_id1_done <= (wait_reg == 4'h1);
			if (i_id1_cmd) begin
				wait_reg <= i_slow ? 4'hC : 4'h2;
			end else if (wait_reg != 4'h0) begin
				wait_reg <= wait_reg - 4'h1;
			end
		end
	end
endmodule : segment_model

// *** sim/record_service_decoder_tb.sv ***
// Testbench: record requests against the decoder and a segment model
module record_service_decoder_tb import record_service_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 1'b0, i_reset_n = 1'b0, i_req_valid = 1'b0, i_req_write = 1'b0;
	logic i_aout_valid = 1'b0, present = 1'b1, slow = 1'b0, id1_seg, o_id1_cmd, o_seg_sel;
	logic o_rsp_valid, o_rsp_last, o_aout_seg, i_id1_done, i_id1_ok, o_busy;
	logic [7:0] i_req_index = 8'h00, i_req_slot = 8'h00, i_req_id1 = 8'h00, i_req_flag = 8'h00;
	logic [7:0] i_aout_addr = 8'h00, i_aout_data = 8'h00, o_rsp_addr, o_rsp_data, o_id1_code;
	logic [7:0] id1_seen, rsp[256];
	logic [31:0] i_seg0_fault_a = 32'hFFFF_FFFF, i_seg0_active_a = 32'h0000_0000;
	logic [31:0] i_seg0_fault_b = 32'hFFFF_FFFF, i_seg0_active_b = 32'h0000_0000;
	logic [31:0] i_seg1_fault_a = 32'hF0F0_A5A3, i_seg1_active_a = 32'hFF00_FF0F;
	logic [31:0] i_seg1_fault_b = 32'h8001_0F0F, i_seg1_active_b = 32'hFFFF_00FF;
	logic [15:0] i_seg0_ain_word, i_seg1_ain_word, o_aout_word;
	logic [6:0] o_ain_word_sel, o_aout_sel;
	logic [1:0] o_auto_addr_en;
	int n_errors = 0, n_checks = 0, rsp_n;

	record_service_decoder dut_u (.i_clk, .i_reset_n, .i_req_valid, .i_req_write, .i_req_index,
		.i_req_slot, .i_req_id1, .i_req_flag, .i_aout_valid, .i_aout_addr, .i_aout_data,
		.o_busy, .o_rsp_valid, .o_rsp_addr, .o_rsp_data, .o_rsp_last, .i_seg0_fault_a,
		.i_seg0_fault_b, .i_seg0_active_a, .i_seg0_active_b, .i_seg1_fault_a, .i_seg1_fault_b,
		.i_seg1_active_a, .i_seg1_active_b, .i_seg0_ain_word, .i_seg1_ain_word, .o_ain_word_sel,
		.o_seg_sel, .o_id1_cmd, .o_id1_code, .i_id1_done, .i_id1_ok, .o_auto_addr_en,
		.o_aout_word, .o_aout_sel, .o_aout_seg);
	segment_model seg_u (.i_clk, .i_reset_n, .i_ain_word_sel(o_ain_word_sel),
		.i_id1_cmd(o_id1_cmd), .i_node0_present(present), .i_slow(slow),
		.o_seg0_ain_word(i_seg0_ain_word), .o_seg1_ain_word(i_seg1_ain_word),
		.o_id1_done(i_id1_done), .o_id1_ok(i_id1_ok));

	// 100 MHz clock
	always #5 i_clk = ~i_clk;
	// Capture each ID1 command
	always @(posedge i_clk) if (o_id1_cmd === 1'b1) {id1_seg, id1_seen} <= {o_seg_sel, o_id1_code};

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// One request, then collect the response bytes up to the status byte
	task automatic do_req(input logic wr, input logic [7:0] idx, input logic [7:0] slot,
		input logic [7:0] val);
		rsp = '{default: 8'hEE};
		rsp_n = 0;
		@(posedge i_clk);
		// Subslot 1 and parameters 0x01 are implied by this request port
		i_req_valid <= 1'b1;
		i_req_write <= wr;
		i_req_index <= idx;
		i_req_slot <= slot;
		i_req_id1 <= val;
		i_req_flag <= val;
		@(posedge i_clk);
		i_req_valid <= 1'b0;
		for (int k = 0; k < 500; k++) begin
			@(negedge i_clk);
			if (o_rsp_valid === 1'b1) begin
				rsp[o_rsp_addr] = o_rsp_data;
				rsp_n++;
				if (o_rsp_last === 1'b1) break;
			end
		end
		chk("response end", 16'h0001, {15'h0000, o_rsp_last});
	endtask : do_req

	task automatic t_auto();
		do_req(1'b1, FN_AUTO_ADDR, SLOT_SEG_ONE, 8'h01);
		chk("auto write status", STATUS_OK, rsp[0]);
		chk("auto enable", 2'b01, o_auto_addr_en);
		do_req(1'b1, FN_AUTO_ADDR, SLOT_SEG_TWO, 8'hFE);
		chk("auto enable bit0", 2'b01, o_auto_addr_en);
		do_req(1'b0, FN_AUTO_ADDR, SLOT_SEG_ONE, 8'h00);
		chk("auto length", 16'h0005, rsp_n[15:0]);
		chk("auto flag", 8'h01, rsp[2]);
		chk("auto status", STATUS_OK, rsp[4]);
		chk("auto pad", 8'h00, rsp[0] | rsp[1] | rsp[3]);
		do_req(1'b0, FN_AUTO_ADDR, SLOT_SEG_TWO, 8'h00);
		chk("auto flag seg two", 8'h00, rsp[2]);
	endtask : t_auto

	task automatic t_fault();
		logic [31:0] la, lb;
		la = i_seg1_fault_a & i_seg1_active_a & 32'hFFFF_FFFE;
		lb = i_seg1_fault_b & i_seg1_active_b & 32'hFFFF_FFFE;
		do_req(1'b0, FN_FAULT_LIST, SLOT_SEG_TWO, 8'h00);
		chk("list length", 16'h000C, rsp_n[15:0]);
		for (int i = 0; i < 4; i++) begin
			chk("list a byte", la[8*i+:8], rsp[2+i]);
			chk("list b byte", lb[8*i+:8], rsp[6+i]);
		end
		chk("list pad", 8'h00, rsp[10]);
		chk("list status", STATUS_OK, rsp[11]);
	endtask : t_fault

	task automatic t_id1();
		do_req(1'b1, FN_WRITE_ID1, SLOT_SEG_ONE, 8'h5C);
		chk("id1 code", 8'h5C, id1_seen);
		chk("id1 ok status", STATUS_OK, rsp[0]);
		present = 1'b0;
		slow = 1'b1;
		do_req(1'b1, FN_WRITE_ID1, SLOT_SEG_TWO, 8'hA3);
		chk("id1 absent status", STATUS_NODE_ABSENT, rsp[0]);
		chk("id1 segment", 16'h0001, {15'h0000, id1_seg});
	endtask : t_id1

	task automatic t_refuse();
		do_req(1'b1, FN_AUTO_ADDR, 8'h05, 8'h00);
		chk("bad slot length", 16'h0001, rsp_n[15:0]);
		chk("bad slot status", STATUS_FAILED, rsp[0]);
		chk("bad slot state", 2'b01, o_auto_addr_en);
		do_req(1'b0, 8'h20, SLOT_SEG_ONE, 8'h00);
		chk("bad index status", STATUS_FAILED, rsp[0]);
		do_req(1'b1, FN_WRITE_ID1, 8'h63, 8'h11);
		chk("bad slot id1", 8'hA3, id1_seen);
		chk("bad slot code", 8'hA3, o_id1_code);
	endtask : t_refuse

	// A request held up while busy is dropped; busy stays up until the status byte
	task automatic t_busy();
		@(posedge i_clk);
		i_req_valid <= 1'b1;
		i_req_write <= 1'b1;
		i_req_index <= FN_WRITE_ID1;
		i_req_slot <= SLOT_SEG_ONE;
		i_req_id1 <= 8'h77;
		@(posedge i_clk);
		i_req_index <= FN_AUTO_ADDR;
		i_req_flag <= 8'h00;
		@(posedge i_clk);
		i_req_valid <= 1'b0;
		@(negedge i_clk);
		chk("busy", 16'h0001, {15'h0000, o_busy});
		for (int k = 0; k < 100 && o_rsp_last !== 1'b1; k++) @(negedge i_clk);
		chk("busy end", 16'h0001, {15'h0000, o_rsp_last});
		chk("busy at end", 16'h0000, {15'h0000, o_busy});
		chk("busy id1 status", STATUS_NODE_ABSENT, o_rsp_data);
		chk("busy request dropped", 2'b01, o_auto_addr_en);
		chk("busy id1 code", 8'h77, id1_seen);
	endtask : t_busy

	task automatic t_ain();
		logic [6:0] w;
		do_req(1'b0, FN_ANALOG_IN, SLOT_SEG_TWO, 8'h00);
		chk("image length", 16'h00FC, rsp_n[15:0]);
		for (int a = 2; a < 250; a++) begin
			w = 7'((a - 2) / 2);
			chk("image byte", a[0] ? {1'b0, ~w} : {1'b1, w}, rsp[a]);
		end
		chk("image pad", 8'h00, rsp[250]);
		chk("image status", STATUS_OK, rsp[251]);
	endtask : t_ain

	task automatic t_aout();
		do_req(1'b1, FN_ANALOG_OUT, SLOT_SEG_TWO, 8'h00);
		chk("aout status", STATUS_OK, rsp[0]);
		// A refused request in between must not retag the segment
		do_req(1'b1, FN_AUTO_ADDR, 8'h05, 8'h00);
		@(posedge i_clk);
		i_aout_valid <= 1'b1;
		i_aout_addr <= 8'hF8;
		i_aout_data <= 8'hC3;
		@(posedge i_clk);
		i_aout_addr <= 8'hF9;
		i_aout_data <= 8'h3C;
		@(posedge i_clk);
		i_aout_valid <= 1'b0;
		for (int k = 0; k < 4 && o_aout_word !== 16'hC33C; k++) @(negedge i_clk);
		chk("aout word", 16'hC33C, o_aout_word);
		chk("aout index", 7'h7B, o_aout_sel);
		chk("aout segment", 16'h0001, {15'h0000, o_aout_seg});
	endtask : t_aout

	task automatic end_sim();
		if (n_errors == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim

	// Main sequence after 16 cycles of reset
	initial begin
		repeat (16) @(posedge i_clk);
		i_reset_n <= 1'b1;
		t_auto();
		t_fault();
		t_id1();
		t_refuse();
		t_busy();
		t_ain();
		t_aout();
		end_sim();
	end
	// Watchdog well beyond the few hundred cycles needed
	initial begin
		#100us;
		n_errors++;
		end_sim();
	end
endmodule : record_service_decoder_tb
